// [frp_pkg.sv]
// constants and types for the read-parameter and write-protect block
package frp_pkg;

  // ****************************************
  // read parameter register layout
  // ****************************************
  localparam logic [7:0] RD_PARAM_RESET = 8'he0;
  localparam int         DS_MSB         = 7;
  localparam int         DS_LSB         = 5;
  localparam int         DC_MSB         = 4;
  localparam int         DC_LSB         = 3;
  localparam int         WRAP_BIT       = 2;
  localparam int         BL_MSB         = 1;
  localparam int         BL_LSB         = 0;
  localparam logic [2:0] DS_RSVD_A      = 3'h0;
  localparam logic [2:0] DS_RSVD_B      = 3'h4;

  // ****************************************
  // status and function register layout
  // ****************************************
  localparam logic [7:0] STATUS_RESET   = 8'h00;
  localparam int         SR_STATUS_WRITE_DISABLE        = 7;
  localparam int         SR_QE          = 6;
  localparam int         SR_BP_MSB      = 5;
  localparam int         SR_BP_LSB      = 2;
  localparam int         FR_TBS         = 1;
  localparam int         BLK_MSB        = 22;
  localparam int         BLK_LSB        = 16;

  // ****************************************
  // instruction codes
  // ****************************************
  localparam logic [7:0] OP_SRP    = 8'hc0;
  localparam logic [7:0] OP_NORD   = 8'h03;
  localparam logic [7:0] OP_FRD    = 8'h0b;
  localparam logic [7:0] OP_FRDTR  = 8'h0d;
  localparam logic [7:0] OP_FRDO   = 8'h3b;
  localparam logic [7:0] OP_FRDIO  = 8'hbb;
  localparam logic [7:0] OP_FRDDTR = 8'hbd;
  localparam logic [7:0] OP_FRQO   = 8'h6b;
  localparam logic [7:0] OP_FRQIO  = 8'heb;
  localparam logic [7:0] OP_FRQDTR = 8'hed;
  localparam logic [7:0] OP_WRITE_ENABLE_CMD   = 8'h06;
  localparam logic [7:0] OP_WRDI   = 8'h04;
  localparam logic [7:0] OP_WRSR   = 8'h01;
  localparam logic [7:0] OP_WRFR   = 8'h42;
  localparam logic [7:0] OP_QPIEN  = 8'h35;
  localparam logic [7:0] OP_QPIDI  = 8'hf5;
  localparam logic [7:0] OP_PP     = 8'h02;
  localparam logic [7:0] OP_PPQA   = 8'h32;
  localparam logic [7:0] OP_PPQB   = 8'h38;
  localparam logic [7:0] OP_SERA   = 8'hd7;
  localparam logic [7:0] OP_SERB   = 8'h20;
  localparam logic [7:0] OP_BER32  = 8'h52;
  localparam logic [7:0] OP_BER64  = 8'hd8;
  localparam logic [7:0] OP_CERA   = 8'hc7;
  localparam logic [7:0] OP_CERB   = 8'h60;

  // ****************************************
  // dummy counts, mode cycles included; the quad and dual tables indexed by field
  // ****************************************
  localparam logic [3:0] DMY_FAST    = 4'h8;
  localparam logic [3:0] DMY_FDTR    = 4'h4;
  localparam logic [3:0] DMY_QIO [4] = '{4'h6, 4'h4, 4'h8, 4'ha};
  localparam logic [3:0] DMY_QDTR[4] = '{4'h3, 4'h2, 4'h4, 4'h5};
  localparam logic [3:0] DMY_DIO [4] = '{4'h4, 4'h4, 4'h8, 4'h8};
  localparam logic [3:0] DMY_DDTR[4] = '{4'h2, 4'h2, 4'h4, 4'h4};

  // ****************************************
  // link framing
  // ****************************************
  localparam logic [5:0] OP_BITS   = 6'h08;
  localparam logic [5:0] DATA_BITS = 6'h10;
  localparam logic [5:0] ADDR_BITS = 6'h20;
  typedef enum logic [1:0] {FRP_ST_OP, FRP_ST_DATA, FRP_ST_ADDR} frp_stage_t;

endpackage

// [frp_link_if.sv]
// bundle carrying decoded serial fields from the link domain to the core
interface frp_link_if;
  import frp_pkg::*;
  logic        ev_tgl;
  frp_stage_t  stage;
  logic [7:0]  opcode;
  logic [23:0] payload;
  modport link (output ev_tgl, output stage, output opcode, output payload);
  modport core (input ev_tgl, input stage, input opcode, input payload);
endinterface

// [frp_link_rx.sv]
// serial-clock side shifter that captures opcode, data byte and address
module frp_link_rx
  import frp_pkg::*;
(
  input  wire logic sck,
  input  wire logic link_rst,
  input  wire logic cs_n,
  input  wire logic si,
  frp_link_if.link  lnk
);
  import frp_pkg::*;

  logic [5:0]  bit_cnt_reg;
  logic [5:0]  bit_cnt_next;
  logic [31:0] shift_reg;
  logic [31:0] shift_next;

  assign bit_cnt_next = bit_cnt_reg + 6'h01;
  assign shift_next   = {shift_reg[30:0], si};

  // the frame's own select ends the count, since sck stops between frames
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_reg <= 6'h00;
    end else if (bit_cnt_reg != ADDR_BITS) begin
      bit_cnt_reg <= bit_cnt_next;
    end
  end

  always_ff @(posedge sck) begin
    shift_reg <= shift_next;
  end

  // fields stay put at least eight sck periods, long enough for the core to sample
  always_ff @(posedge sck or posedge link_rst) begin
    if (link_rst) begin
      lnk.ev_tgl  <= 1'b0;
      lnk.stage   <= FRP_ST_OP;
      lnk.opcode  <= 8'h00;
      lnk.payload <= 24'h000000;
    end else if (bit_cnt_reg != ADDR_BITS) begin
      if (bit_cnt_next == OP_BITS) begin
        lnk.opcode <= shift_next[7:0];
        lnk.stage  <= FRP_ST_OP;
        lnk.ev_tgl <= ~lnk.ev_tgl;
      end else if (bit_cnt_next == DATA_BITS) begin
        lnk.payload <= {16'h0000, shift_next[7:0]};
        lnk.stage   <= FRP_ST_DATA;
        lnk.ev_tgl  <= ~lnk.ev_tgl;
      end else if (bit_cnt_next == ADDR_BITS) begin
        lnk.payload <= shift_next[23:0];
        lnk.stage   <= FRP_ST_ADDR;
        lnk.ev_tgl  <= ~lnk.ev_tgl;
      end
    end
  end
endmodule

// [frp_dummy_lut.sv]
// dummy-cycle count per read instruction and parameter field
module frp_dummy_lut
  import frp_pkg::*;
#(
  parameter logic [7:0] UID_OP  = 8'h91,
  parameter logic [7:0] SFDP_OP = 8'h92,
  parameter logic [7:0] INFO_ROW_READ_CMD_OP = 8'h93
)
(
  input  wire logic [7:0] opcode,
  input  wire logic       quad_cmd,
  input  wire logic [1:0] dummy_sel,
  output logic      [3:0] dummy,
  output logic            is_read
);
  import frp_pkg::*;

  // counts already include the mode-bit cycles after the address
  always_comb begin
    dummy   = 4'h0;
    is_read = 1'b1;
    case (opcode)
      OP_NORD:                            dummy = 4'h0;
      OP_FRD, UID_OP, SFDP_OP, INFO_ROW_READ_CMD_OP: begin
        dummy = quad_cmd ? DMY_QIO[dummy_sel] : DMY_FAST;
      end
      OP_FRDTR: dummy = quad_cmd ? DMY_QDTR[dummy_sel] : DMY_FDTR;
      OP_FRDO, OP_FRQO:                   dummy = DMY_FAST;
      OP_FRQIO:                           dummy = DMY_QIO[dummy_sel];
      OP_FRQDTR:                          dummy = DMY_QDTR[dummy_sel];
      OP_FRDIO:                           dummy = DMY_DIO[dummy_sel];
      OP_FRDDTR:                          dummy = DMY_DDTR[dummy_sel];
      default:                            is_read = 1'b0;
    endcase
  end
endmodule

// [frp_top.sv]
// read-parameter register, write-enable latch and write-protection gating
module frp_top
  import frp_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic        si,
  input  wire logic        wp_n,
  output logic      [2:0]  drive_strength,
  output logic      [3:0]  dummy_cycles,
  output logic             dummy_valid,
  output logic             wrap_enable,
  output logic      [5:0]  wrap_mask,
  output logic      [7:0]  status_bits,
  output logic             write_enable_latch,
  output logic             top_bottom_select,
  output logic             quad_command_mode,
  output logic             quad_enable,
  output logic             pe_go,
  output logic      [7:0]  pe_opcode,
  output logic      [23:0] pe_addr
);
  import frp_pkg::*;

  // ****************************************
  // link domain and crossing
  // ****************************************
  frp_link_if lnk ();

  frp_link_rx u_rx (
    .sck      (sck),
    .link_rst (sys_rst),
    .cs_n     (cs_n),
    .si       (si),
    .lnk      (lnk)
  );

  logic ev_s1_reg;
  logic ev_s2_reg;
  logic ev_s3_reg;
  logic wp_s1_reg;
  logic wp_s2_reg;
  logic ev;

  // toggle crossing; fields are sampled only once the toggle has settled
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ev_s1_reg <= 1'b0;
      ev_s2_reg <= 1'b0;
      ev_s3_reg <= 1'b0;
    end else begin
      ev_s1_reg <= lnk.ev_tgl;
      ev_s2_reg <= ev_s1_reg;
      ev_s3_reg <= ev_s2_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wp_s1_reg <= 1'b1;
      wp_s2_reg <= 1'b1;
    end else begin
      wp_s1_reg <= wp_n;
      wp_s2_reg <= wp_s1_reg;
    end
  end

  assign ev = ev_s2_reg ^ ev_s3_reg;

  // ****************************************
  // event decode
  // ****************************************
  logic ev_op;
  logic ev_data;
  logic ev_addr;
  logic is_prog_erase;
  logic is_chip_erase;

  assign ev_op   = ev && (lnk.stage == FRP_ST_OP);
  assign ev_data = ev && (lnk.stage == FRP_ST_DATA);
  assign ev_addr = ev && (lnk.stage == FRP_ST_ADDR);

  always_comb begin
    is_prog_erase = 1'b0;
    is_chip_erase = 1'b0;
    case (lnk.opcode)
      OP_PP, OP_PPQA, OP_PPQB, OP_SERA, OP_SERB, OP_BER32, OP_BER64: is_prog_erase = 1'b1;
      OP_CERA, OP_CERB: is_chip_erase = 1'b1;
      default: is_prog_erase = 1'b0;
    endcase
  end

  // ****************************************
  // read parameter register
  // ****************************************
  logic [7:0] read_parameters_reg;
  logic [2:0] ds_new;

  assign ds_new = lnk.payload[DS_MSB:DS_LSB];

  // reserved drive codes leave the old drive setting, other fields still load
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      read_parameters_reg <= RD_PARAM_RESET;
    end else if (ev_data && lnk.opcode == OP_SRP) begin
      read_parameters_reg[DC_MSB:BL_LSB] <= lnk.payload[DC_MSB:BL_LSB];
      if (ds_new != DS_RSVD_A && ds_new != DS_RSVD_B) begin
        read_parameters_reg[DS_MSB:DS_LSB] <= ds_new;
      end
    end
  end

  logic [1:0] burst_sel;

  assign burst_sel      = read_parameters_reg[BL_MSB:BL_LSB];
  assign drive_strength = read_parameters_reg[DS_MSB:DS_LSB];
  assign wrap_enable    = read_parameters_reg[WRAP_BIT];
  // address bits that wrap; zero means the read runs across the array
  assign wrap_mask = {6{wrap_enable}} & {burst_sel == 2'h3, burst_sel[1], |burst_sel, 3'h7};

  // ****************************************
  // dummy count for the current read
  // ****************************************
  logic [3:0] lut_dummy;
  logic       lut_is_read;

  frp_dummy_lut u_lut (
    .opcode    (lnk.opcode),
    .quad_cmd  (quad_command_mode),
    .dummy_sel (read_parameters_reg[DC_MSB:DC_LSB]),
    .dummy     (lut_dummy),
    .is_read   (lut_is_read)
  );

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      dummy_cycles <= 4'h0;
      dummy_valid  <= 1'b0;
    end else if (ev_op) begin
      dummy_cycles <= lut_dummy;
      dummy_valid  <= lut_is_read;
    end
  end

  // ****************************************
  // write enable latch and modes
  // ****************************************
  logic sr_locked;
  logic wr_done;

  assign sr_locked = status_bits[SR_STATUS_WRITE_DISABLE] && !wp_s2_reg;
  assign wr_done   = (ev_data && (lnk.opcode == OP_WRSR || lnk.opcode == OP_WRFR))
                     || pe_go;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      write_enable_latch <= 1'b0;
    end else if (ev_op && lnk.opcode == OP_WRITE_ENABLE_CMD) begin
      write_enable_latch <= 1'b1;
    end else if ((ev_op && lnk.opcode == OP_WRDI) || wr_done) begin
      write_enable_latch <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      quad_command_mode <= 1'b0;
    end else if (ev_op && lnk.opcode == OP_QPIEN) begin
      quad_command_mode <= 1'b1;
    end else if (ev_op && lnk.opcode == OP_QPIDI) begin
      quad_command_mode <= 1'b0;
    end
  end

  // ****************************************
  // status and function register bits
  // ****************************************
  // a locked status write or a write without the latch changes nothing
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      status_bits <= STATUS_RESET;
    end else if (ev_data && lnk.opcode == OP_WRSR && write_enable_latch && !sr_locked) begin
      status_bits[SR_STATUS_WRITE_DISABLE]             <= lnk.payload[SR_STATUS_WRITE_DISABLE];
      status_bits[SR_QE]               <= lnk.payload[SR_QE];
      status_bits[SR_BP_MSB:SR_BP_LSB] <= lnk.payload[SR_BP_MSB:SR_BP_LSB];
    end
  end

  assign quad_enable = status_bits[SR_QE];

  // once bottom is chosen it stays; zero writes are simply ignored
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      top_bottom_select <= 1'b0;
    end else if (ev_data && lnk.opcode == OP_WRFR && write_enable_latch
                 && lnk.payload[FR_TBS]) begin
      top_bottom_select <= 1'b1;
    end
  end

  // ****************************************
  // block protection and program/erase gating
  // ****************************************
  function automatic logic blk_protected(input logic [6:0] blk,
                                         input logic [3:0] bp,
                                         input logic       bottom);
    logic [7:0] span;
    logic [7:0] blk_w;
    span  = 8'h01 << (bp[2:0] - 3'h1);
    blk_w = {1'b0, blk};
    if (bp[3]) begin
      blk_protected = 1'b1;
    end else if (bp == 4'h0) begin
      blk_protected = 1'b0;
    end else if (bottom) begin
      blk_protected = blk_w < span;
    end else begin
      blk_protected = blk_w >= (8'h80 - span);
    end
  endfunction

  logic [3:0] bp_bits;
  logic       addr_ok;
  logic       chip_ok;

  assign bp_bits = status_bits[SR_BP_MSB:SR_BP_LSB];
  assign addr_ok = !blk_protected(lnk.payload[BLK_MSB:BLK_LSB], bp_bits, top_bottom_select);
  assign chip_ok = bp_bits == 4'h0;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pe_go <= 1'b0;
    end else begin
      pe_go <= write_enable_latch && ((ev_addr && is_prog_erase && addr_ok)
               || (ev_op && is_chip_erase && chip_ok));
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pe_opcode <= 8'h00;
      pe_addr   <= 24'h000000;
    end else if (ev_addr || (ev_op && is_chip_erase)) begin
      pe_opcode <= lnk.opcode;
      pe_addr   <= ev_addr ? lnk.payload : 24'h000000;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  srp_load_a: assert property (@(posedge clock) disable iff (sys_rst)
    ev_data && lnk.opcode == OP_SRP |=>
      read_parameters_reg[DC_MSB:BL_LSB] == $past(lnk.payload[DC_MSB:BL_LSB]))
    else $error("parameter byte not loaded");

  wrap_off_a: assert property (@(posedge clock) disable iff (sys_rst)
    !read_parameters_reg[WRAP_BIT] |-> wrap_mask == 6'h00)
    else $error("wrap mask set while wrap off");

  wrap_len_a: assert property (@(posedge clock) disable iff (sys_rst)
    wrap_enable && burst_sel == 2'h2 |-> wrap_mask == 6'h1f)
    else $error("32 byte wrap mask wrong");

  dummy_norm_a: assert property (@(posedge clock) disable iff (sys_rst)
    ev_op && lnk.opcode == OP_NORD |=> dummy_valid && dummy_cycles == 4'h0)
    else $error("normal read dummy not zero");

  dummy_fast_a: assert property (@(posedge clock) disable iff (sys_rst)
    ev_op && lnk.opcode == OP_FRD && !quad_command_mode |=> dummy_cycles == 4'h8)
    else $error("spi fast read dummy not eight");

  dummy_qio_a: assert property (@(posedge clock) disable iff (sys_rst)
    ev_op && lnk.opcode == OP_FRQIO && read_parameters_reg[DC_MSB:DC_LSB] == 2'h3
      |=> dummy_cycles == 4'ha)
    else $error("quad io dummy not ten");

  drive_code_a: assert property (@(posedge clock) disable iff (sys_rst)
    drive_strength != DS_RSVD_A && drive_strength != DS_RSVD_B)
    else $error("reserved drive code held");

  sr_lock_a: assert property (@(posedge clock) disable iff (sys_rst)
    ev_data && lnk.opcode == OP_WRSR && sr_locked |=> $stable(status_bits))
    else $error("locked status changed");

  wel_gate_a: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(status_bits[SR_QE]) || $rose(pe_go) |-> $past(write_enable_latch))
    else $error("write done without latch");

  region_a: assert property (@(posedge clock) disable iff (sys_rst)
    pe_go |-> !blk_protected(pe_addr[BLK_MSB:BLK_LSB], bp_bits, top_bottom_select)
              || is_chip_erase || chip_ok)
    else $error("program into protected block");

  tbs_keep_a: assert property (@(posedge clock) disable iff (sys_rst)
    top_bottom_select |=> top_bottom_select)
    else $error("bottom select cleared");

  rst_default_a: assert property (@(posedge clock)
    $past(sys_rst) && !sys_rst |-> read_parameters_reg == RD_PARAM_RESET)
    else $error("parameter reset value wrong");

  chip_gate_a: assert property (@(posedge clock) disable iff (sys_rst)
    ev_op && is_chip_erase && !chip_ok |=> !pe_go)
    else $error("chip erase while blocks protected");

  pe_nolatch_a: assert property (@(posedge clock) disable iff (sys_rst)
    ev_addr && is_prog_erase && !write_enable_latch |=> !pe_go)
    else $error("program without latch");

  sr_nolatch_a: assert property (@(posedge clock) disable iff (sys_rst)
    ev_data && lnk.opcode == OP_WRSR && !write_enable_latch |=> $stable(status_bits))
    else $error("status written without latch");

  drive_keep_a: assert property (@(posedge clock) disable iff (sys_rst)
    ev_data && lnk.opcode == OP_SRP && (ds_new == DS_RSVD_A || ds_new == DS_RSVD_B)
      |=> $stable(drive_strength))
    else $error("reserved drive code loaded");

  dummy_spi_a: assert property (@(posedge clock) disable iff (sys_rst)
    ev_op && (lnk.opcode == OP_FRDO || lnk.opcode == OP_FRQO) |=> dummy_cycles == 4'h8)
    else $error("spi output read dummy not eight");

  dummy_dio_a: assert property (@(posedge clock) disable iff (sys_rst)
    ev_op && lnk.opcode == OP_FRDIO && read_parameters_reg[DC_MSB:DC_LSB] == 2'h2
      |=> dummy_cycles == 4'h8)
    else $error("dual io dummy not eight");

  dummy_qdtr_a: assert property (@(posedge clock) disable iff (sys_rst)
    ev_op && lnk.opcode == OP_FRQDTR && read_parameters_reg[DC_MSB:DC_LSB] == 2'h1
      |=> dummy_cycles == 4'h2)
    else $error("quad dtr dummy not two");

  qpi_fast_a: assert property (@(posedge clock) disable iff (sys_rst)
    ev_op && lnk.opcode == OP_FRD && quad_command_mode
      && read_parameters_reg[DC_MSB:DC_LSB] == 2'h0 |=> dummy_cycles == 4'h6)
    else $error("quad mode fast read dummy not six");

  wrap_len8_a: assert property (@(posedge clock) disable iff (sys_rst)
    wrap_enable && burst_sel == 2'h0 |-> wrap_mask == 6'h07)
    else $error("8 byte wrap mask wrong");

  bottom_blk_a: assert property (@(posedge clock) disable iff (sys_rst)
    pe_go && top_bottom_select && bp_bits == 4'h1 |-> pe_addr[BLK_MSB:BLK_LSB] != 7'h00)
    else $error("bottom block erased while protected");

endmodule

// [frp_host_model.sv]
// serial host model that shifts instruction frames into the block
module frp_host_model (
  output logic sck,
  output logic cs_n,
  output logic si
);
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // idle levels
  // ****************************************
  initial begin
    sck  = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end

  // ****************************************
  // one frame, msb first, bits left aligned
  // ****************************************
  // clock stands still outside frames; the gap after a frame covers the
  // core's sync latency before the next opcode can complete
  task automatic frame(input logic [31:0] bits, input int n);
    cs_n = 1'b0;
    #3;
    for (int i = 0; i < n; i++) begin
      si = bits[31-i];
      #3 sck = 1'b1;
      #3 sck = 1'b0;
    end
    #3 cs_n = 1'b1;
    // a released line must not keep showing the last bit
    // single lane, nothing driven in mode or dummy cycles, so no contention
    si = ~si;
    #40;
  endtask
endmodule

// [frp_top_tb.sv]
// self-checking bench for the read-parameter and write-protect block
module frp_top_tb;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // signals
  // ****************************************
  logic        clock;
  logic        sys_rst;
  logic        wp_n;
  wire         sck;
  wire         cs_n;
  wire         si;
  logic [2:0]  drive_strength;
  logic [3:0]  dummy_cycles;
  logic        dummy_valid;
  logic        wrap_enable;
  logic [5:0]  wrap_mask;
  logic [7:0]  status_bits;
  logic        write_enable_latch;
  logic        top_bottom_select;
  logic        quad_command_mode;
  logic        quad_enable;
  logic        pe_go;
  logic [7:0]  pe_opcode;
  logic [23:0] pe_addr;
  logic [7:0]  go_op;
  logic [23:0] go_addr;
  logic [2:0]  ds_exp;
  int          n_fail;
  int          n_tests;
  int          n_go;
  int          cyc;
  logic [3:0]  t_qio  [4] = '{4'h6, 4'h4, 4'h8, 4'ha};
  logic [3:0]  t_qdtr [4] = '{4'h3, 4'h2, 4'h4, 4'h5};
  logic [3:0]  t_dio  [4] = '{4'h4, 4'h4, 4'h8, 4'h8};
  logic [3:0]  t_ddtr [4] = '{4'h2, 4'h2, 4'h4, 4'h4};

  frp_top frp_top_inst (
    .clock              (clock),
    .sys_rst            (sys_rst),
    .sck                (sck),
    .cs_n               (cs_n),
    .si                 (si),
    .wp_n               (wp_n),
    .drive_strength     (drive_strength),
    .dummy_cycles       (dummy_cycles),
    .dummy_valid        (dummy_valid),
    .wrap_enable        (wrap_enable),
    .wrap_mask          (wrap_mask),
    .status_bits        (status_bits),
    .write_enable_latch (write_enable_latch),
    .top_bottom_select  (top_bottom_select),
    .quad_command_mode  (quad_command_mode),
    .quad_enable        (quad_enable),
    .pe_go              (pe_go),
    .pe_opcode          (pe_opcode),
    .pe_addr            (pe_addr)
  );

  frp_host_model frp_host_model_inst (
    .sck  (sck),
    .cs_n (cs_n),
    .si   (si)
  );

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // ****************************************
  // pulse capture and hang guard
  // ****************************************
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (pe_go === 1'b1) begin
      n_go    <= n_go + 1;
      go_op   <= pe_opcode;
      go_addr <= pe_addr;
    end
    if (cyc == 20000) begin
      n_fail++;
      test_done();
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // covers the worst sync latency with margin
  task automatic settle;
    repeat (8) @(posedge clock);
  endtask

  task automatic send(input logic [31:0] bits, input int n);
    frp_host_model_inst.frame(bits, n);
    settle();
  endtask

  task automatic rd(input logic [7:0] op, input logic [3:0] exp);
    send({op, 24'h0}, 8);
    chk(32'(dummy_valid), 1, "read seen");
    chk(32'(dummy_cycles), 32'(exp), "dummy count");
  endtask

  task automatic erase(input logic [7:0] op, input logic [23:0] a, input int n, input int ok);
    int g;
    g = n_go;
    send(32'h06000000, 8);
    send({op, a}, n);
    chk(n_go - g, ok, "erase pulses");
    chk(32'(write_enable_latch), 32'(ok == 0), "latch after erase");
    if (ok != 0) begin
      chk(32'(go_op), 32'(op), "erase opcode");
      chk(32'(go_addr), 32'(a), "erase address");
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    chk(32'(drive_strength), 7, "drive default");
    chk(32'(wrap_enable), 0, "wrap default");
    chk(32'(wrap_mask), 0, "mask default");
    chk(32'(status_bits), 0, "status default");
    chk(32'(write_enable_latch), 0, "latch default");
    chk(32'(dummy_valid), 0, "dummy default");
    chk(n_go, 0, "no pulse in reset");
    $display("test reset done");
  endtask

  task automatic t_params;
    ds_exp = 3'h7;
    for (int i = 0; i < 8; i++) begin
      send({8'hc0, i[2:0], 2'b01, 1'b1, i[1:0], 16'h0}, 16);
      if (i != 0 && i != 4)
        ds_exp = i[2:0];
      chk(32'(drive_strength), 32'(ds_exp), "drive code");
      chk(32'(wrap_enable), 1, "wrap on");
      chk(32'(wrap_mask), (8 << i[1:0]) - 1, "wrap mask");
    end
    send(32'hc0e30000, 16);
    chk(32'(wrap_mask), 0, "wrap off ignores burst");
    chk(32'(drive_strength), 7, "drive reloaded");
    $display("test params done");
  endtask

  task automatic t_dummy;
    for (int s = 0; s < 4; s++) begin
      send({8'hc0, 3'h7, s[1:0], 3'h0, 16'h0}, 16);
      rd(8'h03, 4'h0);
      rd(8'h0b, 4'h8);
      rd(8'h3b, 4'h8);
      rd(8'h6b, 4'h8);
      rd(8'h91, 4'h8);
      rd(8'h92, 4'h8);
      rd(8'h93, 4'h8);
      rd(8'heb, t_qio[s]);
      rd(8'hed, t_qdtr[s]);
      rd(8'hbb, t_dio[s]);
      rd(8'hbd, t_ddtr[s]);
      rd(8'h0d, 4'h4);
      send(32'h35000000, 8);
      chk(32'(quad_command_mode), 1, "quad mode on");
      rd(8'h0b, t_qio[s]);
      rd(8'h0d, t_qdtr[s]);
      send(32'hf5000000, 8);
      chk(32'(quad_command_mode), 0, "quad mode off");
    end
    send(32'h04000000, 8);
    chk(32'(dummy_valid), 0, "non-read opcode");
    $display("test dummy done");
  endtask

  task automatic t_latch;
    send(32'h013c0000, 16);
    chk(32'(status_bits), 0, "status write without latch");
    send(32'h20123456, 32);
    chk(n_go, 0, "erase without latch");
    send(32'h06000000, 8);
    chk(32'(write_enable_latch), 1, "latch set");
    send(32'h04000000, 8);
    chk(32'(write_enable_latch), 0, "latch cleared");
    erase(8'h20, 24'h123456, 32, 1);
    erase(8'hc7, 24'h0, 8, 1);
    $display("test latch done");
  endtask

  task automatic t_protect;
    send(32'h06000000, 8);
    send(32'h01840000, 16);
    chk(32'(status_bits), 32'h84, "status written");
    erase(8'h20, 24'h7f0000, 32, 0);
    erase(8'hd8, 24'h000000, 32, 1);
    erase(8'h60, 24'h0, 8, 0);
    wp_n <= 1'b0;
    settle();
    send(32'h06000000, 8);
    send(32'h01000000, 16);
    chk(32'(status_bits), 32'h84, "status locked by pin");
    wp_n <= 1'b1;
    settle();
    send(32'h06000000, 8);
    send(32'h01440000, 16);
    chk(32'(status_bits), 32'h44, "status free with pin high");
    chk(32'(quad_enable), 1, "quad enable written");
    send(32'h06000000, 8);
    send(32'h42020000, 16);
    chk(32'(top_bottom_select), 1, "bottom selected");
    erase(8'h20, 24'h000000, 32, 0);
    erase(8'h52, 24'h7f0000, 32, 1);
    send(32'h06000000, 8);
    send(32'h42000000, 16);
    chk(32'(top_bottom_select), 1, "bottom is one-way");
    $display("test protect done");
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    sys_rst = 1'b1;
    wp_n    = 1'b1;
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clock);
    t_reset();
    t_params();
    t_dummy();
    t_latch();
    t_protect();
    test_done();
  end
endmodule
